// ### verilog/lacg_top.sv
// Purpose: alignment config octets, 20-cycle sample pipe, output format
// Assumes: i_sample arrives offset binary from the converter core
// Notes:   config pins are asynchronous and pass two flip-flops
//
// Overview of operation
// - after reset no alignment sequence; sent only once explicitly enabled
// - lane count, octets per frame and K default follow 20x or 10x mode; lane id follows the lane
// - octet 7 holds CS 00, N 01101; octet 8 N' 01111; others zero
// - octet 11, first reserved octet, is sent as all zeros
// - octet 12, second reserved octet, is sent as all zeros
// - octets 0 to 13 per lane; octet 3 scramble bit; octet 13 checksum
// - each sample leaves the output 20 clocks after its capture edge
// - 14-bit samples, offset binary or twos complement as configured
// - sampling and conversion start on the rising sampling clock edge
// - multiframe field defaults to 16 in 10x mode, 8 in 20x mode
// - with override set, programmed 5-bit value replaces the default
`timescale 1ns/100ps
module lacg_top #(
  parameter int unsigned LATENCY = lacg_pkg::PIPE_LATENCY
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  input  wire lacg_pkg::lacg_cfg_t               i_cfg,
  input  wire logic [lacg_pkg::SAMPLE_W-1:0]     i_sample,
  output logic      [lacg_pkg::SAMPLE_W-1:0]     o_sample,
  output lacg_pkg::lacg_octets_t                 o_octets,
  output logic                                   o_ilas_busy,
  output logic      [4:0]                        o_mf_frames_m1
);

  localparam int unsigned SW = lacg_pkg::SAMPLE_W;

  // refused at elaboration: the pipe needs a capture and a shift stage
  if (LATENCY < 2) begin : g_latency_check
    $error("lacg_top: LATENCY must be at least 2");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } lacg_state_t;

  // multiframe length, default by mode or the programmed override
  function automatic logic [4:0] k_field(input lacg_pkg::lacg_cfg_t c);
    logic [4:0] k;
    k = c.frame_20x ? lacg_pkg::K_DEF_20X : lacg_pkg::K_DEF_10X;
    if (c.k_override) begin
      k = c.k_value;
    end
    return k;
  endfunction

  // configuration octet for one lane; unused bits go out as zero
  function automatic logic [7:0] cfg_octet(input lacg_pkg::lacg_cfg_t c,
                                           input logic [3:0] idx,
                                           input logic lane);
    logic [7:0] o;
    logic [4:0] lid;
    o   = 8'h00;
    lid = lane ? lacg_pkg::LID_LANE1 : lacg_pkg::LID_LANE0;
    case (idx)
      lacg_pkg::OCT_DID:   o = lacg_pkg::DID_VAL;
      lacg_pkg::OCT_BID:   o = {4'h0, lacg_pkg::BID_VAL};
      lacg_pkg::OCT_LID:   o = {3'h0, lid};
      lacg_pkg::OCT_SCR_L: o = {c.scramble_select, 2'h0,
                                 c.frame_20x ? lacg_pkg::L_20X
                                             : lacg_pkg::L_10X};
      lacg_pkg::OCT_F:     o = c.frame_20x ? lacg_pkg::F_20X
                                           : lacg_pkg::F_10X;
      lacg_pkg::OCT_K:     o = {3'h0, k_field(c)};
      lacg_pkg::OCT_M:     o = lacg_pkg::M_VAL;
      lacg_pkg::OCT_CS_N:  o = {lacg_pkg::CS_VAL, 1'b0,
                                 lacg_pkg::N_VAL};
      lacg_pkg::OCT_NP:    o = {3'h0, lacg_pkg::NP_VAL};
      lacg_pkg::OCT_S:     o = {3'h0, lacg_pkg::S_VAL};
      lacg_pkg::OCT_HD_CF: o = {lacg_pkg::HD_VAL, 2'h0, lacg_pkg::CF_VAL};
      lacg_pkg::OCT_RES1:  o = lacg_pkg::RES_VAL;
      lacg_pkg::OCT_RES2:  o = lacg_pkg::RES_VAL;
      lacg_pkg::OCT_FCHK:  o = fchk(c, lane);
      default:             o = 8'h00;
    endcase
    return o;
  endfunction

  // modulo-256 sum of field values; the octet 3 scramble bit counts as 1, not 128
  function automatic logic [7:0] fchk(input lacg_pkg::lacg_cfg_t c,
                                      input logic lane);
    logic [7:0] s;
    logic [4:0] lid;
    lid = lane ? lacg_pkg::LID_LANE1 : lacg_pkg::LID_LANE0;
    s = lacg_pkg::DID_VAL + {4'h0, lacg_pkg::BID_VAL} + {3'h0, lid}
      + {7'h00, c.scramble_select}
      + {3'h0, c.frame_20x ? lacg_pkg::L_20X : lacg_pkg::L_10X}
      + (c.frame_20x ? lacg_pkg::F_20X : lacg_pkg::F_10X)
      + {3'h0, k_field(c)} + lacg_pkg::M_VAL
      + {6'h00, lacg_pkg::CS_VAL} + {3'h0, lacg_pkg::N_VAL}
      + {3'h0, lacg_pkg::NP_VAL} + {3'h0, lacg_pkg::S_VAL}
      + {7'h00, lacg_pkg::HD_VAL} + {3'h0, lacg_pkg::CF_VAL};
    return s;
  endfunction

  // two-stage synchroniser on the config pins, plus a third for edges
  lacg_pkg::lacg_cfg_t cfg_meta_r;
  lacg_pkg::lacg_cfg_t cfg_r;
  logic                en_prev_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_meta_r <= '0;
      cfg_r      <= '0;
      en_prev_r  <= 1'b0;
    end else begin
      cfg_meta_r <= i_cfg;
      cfg_r      <= cfg_meta_r;
      en_prev_r  <= cfg_r.ilas_en;
    end
  end

  // the sequence starts only on the enable's rising edge, never at reset
  wire logic start_w = cfg_r.ilas_en & ~en_prev_r;

  lacg_state_t state_r;
  lacg_state_t state_nxt;
  logic [3:0]  idx_r;
  logic [3:0]  idx_nxt;

  wire logic last_w = (idx_r == lacg_pkg::OCT_FCHK);

  // sequencer: idle until enabled, then octets 0..13 back to back
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    unique case (state_r)
      ST_IDLE: begin
        idx_nxt = 4'h0;
        if (start_w) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        idx_nxt = idx_r + 4'h1;
        if (last_w || !cfg_r.ilas_en) begin
          state_nxt = ST_IDLE;
          idx_nxt   = 4'h0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        idx_nxt   = 4'h0;
      end
    endcase
  end

  // octet lanes; lane 1 carries nothing in single-lane 20x mode
  wire logic       sending_w = (state_r == ST_SEND) & cfg_r.ilas_en;
  wire logic [7:0] lane0_w   = cfg_octet(cfg_r, idx_r, 1'b0);
  wire logic [7:0] lane1_w   = cfg_r.frame_20x ? 8'h00
                                               : cfg_octet(cfg_r, idx_r, 1'b1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r        <= ST_IDLE;
      idx_r          <= 4'h0;
      o_octets       <= '0;
      o_ilas_busy    <= 1'b0;
      o_mf_frames_m1 <= 5'h00;
    end else begin
      state_r        <= state_nxt;
      idx_r          <= idx_nxt;
      o_octets.valid <= sending_w;
      o_octets.index <= sending_w ? idx_r : 4'h0;
      o_octets.lane0 <= sending_w ? lane0_w : 8'h00;
      o_octets.lane1 <= sending_w ? lane1_w : 8'h00;
      o_ilas_busy    <= sending_w;
      o_mf_frames_m1 <= k_field(cfg_r);
    end
  end

  // sample pipe: capture stage plus LATENCY-1 shifts, then the output flop,
  // so a sample shows exactly LATENCY edges after the edge that took it
  logic [SW-1:0] pipe_r [LATENCY];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      pipe_r[0] <= i_sample;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // format applied at the last stage so a mode change acts at once
  wire logic [SW-1:0] fmt_w = {pipe_r[LATENCY-1][SW-1] ^ cfg_r.twos_comp,
                               pipe_r[LATENCY-1][SW-2:0]};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= '0;
    end else begin
      o_sample <= fmt_w;
    end
  end

endmodule

// ### common/lacg_pkg.sv
// Purpose: constants and carriers for the lane alignment config generator
// Assumes: one converter sampling clock, two output lanes
// Notes:   field values are fixed by the converter's build
package lacg_pkg;

  // octet numbering of the configuration sequence
  localparam int unsigned OCT_COUNT = 14;
  localparam logic [3:0]  OCT_DID   = 4'h0;
  localparam logic [3:0]  OCT_BID   = 4'h1;
  localparam logic [3:0]  OCT_LID   = 4'h2;
  localparam logic [3:0]  OCT_SCR_L = 4'h3;
  localparam logic [3:0]  OCT_F     = 4'h4;
  localparam logic [3:0]  OCT_K     = 4'h5;
  localparam logic [3:0]  OCT_M     = 4'h6;
  localparam logic [3:0]  OCT_CS_N  = 4'h7;
  localparam logic [3:0]  OCT_NP    = 4'h8;
  localparam logic [3:0]  OCT_S     = 4'h9;
  localparam logic [3:0]  OCT_HD_CF = 4'ha;
  localparam logic [3:0]  OCT_RES1  = 4'hb;
  localparam logic [3:0]  OCT_RES2  = 4'hc;
  localparam logic [3:0]  OCT_FCHK  = 4'hd;
  localparam logic [3:0]  OCT_LAST_SUMMED = OCT_HD_CF;

  // link parameter field values
  localparam logic [7:0] DID_VAL   = 8'h00;
  localparam logic [3:0] BID_VAL   = 4'h0;
  localparam logic [4:0] LID_LANE0 = 5'h00;
  localparam logic [4:0] LID_LANE1 = 5'h01;
  localparam logic [4:0] L_20X     = 5'h00;
  localparam logic [4:0] L_10X     = 5'h01;
  localparam logic [7:0] F_20X     = 8'h01;
  localparam logic [7:0] F_10X     = 8'h00;
  localparam logic [4:0] K_DEF_20X = 5'h08;
  localparam logic [4:0] K_DEF_10X = 5'h10;
  localparam logic [7:0] M_VAL     = 8'h00;
  localparam logic [1:0] CS_VAL    = 2'h0;
  localparam logic [4:0] N_VAL     = 5'h0d;
  localparam logic [4:0] NP_VAL    = 5'h0f;
  localparam logic [4:0] S_VAL     = 5'h00;
  localparam logic       HD_VAL    = 1'b0;
  localparam logic [4:0] CF_VAL    = 5'h00;
  localparam logic [7:0] RES_VAL   = 8'h00;

  // datapath
  localparam int unsigned SAMPLE_W     = 14;
  localparam int unsigned PIPE_LATENCY = 20;

  // static configuration carried in from the control pins
  typedef struct packed {
    logic       ilas_en;     // send the alignment sequence
    logic       frame_20x;   // 1: 20x single lane, 0: 10x dual lane
    logic       scramble_select;
    logic       k_override;
    logic [4:0] k_value;
    logic       twos_comp;   // 1: twos complement, 0: offset binary
  } lacg_cfg_t;

  // one octet on each lane
  typedef struct packed {
    logic       valid;
    logic [3:0] index;
    logic [7:0] lane0;
    logic [7:0] lane1;
  } lacg_octets_t;

endpackage

// ### tb/lacg_chk.sv
// Purpose: port checks for the alignment config generator
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every lacg_top instance
`timescale 1ns/100ps
module lacg_chk #(
  parameter int unsigned LATENCY = 20
) (
  input wire logic                          i_clk,
  input wire logic                          i_rst_n,
  input wire lacg_pkg::lacg_cfg_t           i_cfg,
  input wire logic [lacg_pkg::SAMPLE_W-1:0] i_sample,
  input wire logic [lacg_pkg::SAMPLE_W-1:0] o_sample,
  input wire lacg_pkg::lacg_octets_t        o_octets,
  input wire logic                          o_ilas_busy,
  input wire logic [4:0]                    o_mf_frames_m1
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // short names for the octet carrier
  wire logic       v  = o_octets.valid;
  wire logic [3:0] ix = o_octets.index;
  wire logic [7:0] l0 = o_octets.lane0;
  wire logic [7:0] l1 = o_octets.lane1;
  a_busy_valid: assert property (o_ilas_busy == v)
    else $error("busy differs from valid");
  // a run may only start three edges after the enable pin was high
  a_start_cause: assert property (
    $rose(v) |-> $past(i_cfg.ilas_en, 3))
    else $error("octets without enable");
  a_first_index: assert property ($rose(v) |-> ix == 4'h0)
    else $error("run not starting at octet 0");
  // a dropped enable may cut a run short, so only a live run must step
  a_index_step: assert property (
    v && ix != 4'hd && $past(i_cfg.ilas_en, 2)
    |=> v && ix == $past(ix) + 4'h1)
    else $error("octet index skipped");
  a_run_ends: assert property (v && ix == 4'hd |=> !v)
    else $error("run longer than 14 octets");
  a_res1_zero: assert property (
    v && ix == 4'hb |-> l0 == 8'h00 && l1 == 8'h00)
    else $error("octet 11 not zero");
  a_res2_zero: assert property (
    v && ix == 4'hc |-> l0 == 8'h00 && l1 == 8'h00)
    else $error("octet 12 not zero");
  a_octet_seven: assert property (
    v && ix == 4'h7 |-> l0 == 8'h0d)
    else $error("octet 7 wrong");
  a_octet_eight: assert property (
    v && ix == 4'h8 |-> l0 == 8'h0f)
    else $error("octet 8 wrong");
  c_run: cover property ($rose(v));
  c_end: cover property (v && ix == 4'hd);
  c_k10: cover property (o_mf_frames_m1 == 5'h10);
endmodule

bind lacg_top lacg_chk #(.LATENCY(LATENCY)) u_chk (.i_clk, .i_rst_n,
  .i_cfg, .i_sample, .o_sample, .o_octets, .o_ilas_busy, .o_mf_frames_m1);

// ### tb/lacg_rx_model.sv
// Purpose: link receiver model capturing alignment octets
// Assumes: one octet per lane per clock while valid
// Notes:   only whole runs are counted, a cut run is not
`timescale 1ns/100ps
module lacg_rx_model (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire lacg_pkg::lacg_octets_t i_oct,
  output int                          o_runs
);
  logic [7:0] l0 [14];
  logic [7:0] l1 [14];
  // store each octet by index, count runs at the checksum octet
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_runs <= 0;
    else if (i_oct.valid) begin
      l0[i_oct.index] <= i_oct.lane0;
      l1[i_oct.index] <= i_oct.lane1;
      if (i_oct.index == 4'hd) o_runs <= o_runs + 1;
    end
  end
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for the alignment config generator
// Assumes: 40 MHz clock, a random sample every cycle
// Notes:   octet fields are modelled with integers
`timescale 1ns/100ps
module testbench;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  lacg_pkg::lacg_cfg_t    cfg = '0;
  logic [13:0]            smp = 14'h0000;
  logic [13:0]            osm;
  logic [4:0]             k;
  logic                   tc = 1'b0;
  lacg_pkg::lacg_octets_t oct;
  logic [13:0]            q [$];
  logic [13:0]            exp_s;
  int runs, error_cnt = 0, checks = 0, cyc = 0, stab = 0;

  lacg_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_sample(smp),
    .o_sample(osm), .o_octets(oct), .o_ilas_busy(), .o_mf_frames_m1(k));
  lacg_rx_model rx (.i_clk(clk), .i_rst_n(rst_n), .i_oct(oct),
    .o_runs(runs));

  initial forever #12.5 clk = ~clk;

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // expected octet i of lane ln; lane 1 is silent in 20x mode
  function automatic int eo(int i, int ln, int f20, int s, int kk);
    int sum = 0;
    if (f20 && ln) return 0;
    case (i)
      2: return ln;
      3: return s * 128 + 1 - f20;
      4: return f20;
      5: return kk;
      7: return 13;
      8: return 15;
      13: begin
        // checksum adds field values, so the scramble bit counts as 1
        for (int j = 0; j < 11; j++) begin
          sum += (j == 3) ? s + 1 - f20 : eo(j, ln, f20, s, kk);
        end
        return sum % 256;
      end
      default: return 0;
    endcase
  endfunction

  // reference pipe; compared only once format and reset have settled
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done;
    end
    if (!rst_n || cfg.twos_comp !== tc) stab = 0;
    else stab++;
    tc = cfg.twos_comp;
    q.push_back(smp);
    if (q.size() > 22) void'(q.pop_front());
    exp_s = q[0] ^ {tc, 13'h0000};
    if (stab > 24) chk(16'(osm), 16'(exp_s));
    smp <= 14'($urandom());
  end

  // one sequence run in a given mode, then a full octet compare
  task automatic run(int f20, int s, int ko, int kv);
    int k0 = ko ? kv : (f20 ? 8 : 16);
    int r0;
    @(posedge clk);
    cfg <= {1'b0, f20[0], s[0], ko[0], kv[4:0], s[0]};
    repeat (5) @(posedge clk);
    r0 = runs;
    cfg.ilas_en <= 1'b1;
    for (int n = 0; n < 30 && runs == r0; n++) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      chk(rx.l0[i], 16'(eo(i, 0, f20, s, k0)));
      chk(rx.l1[i], 16'(eo(i, 1, f20, s, k0)));
    end
    chk(16'(k), 16'(k0));
    chk(16'(runs), 16'(r0 + 1));
  endtask

  initial begin
    void'($urandom(32'h956f));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    chk(16'(runs), 16'h0000);
    for (int m = 0; m < 8; m++) begin
      run(m & 1, (m >> 1) & 1, m >> 2, $urandom % 32);
    end
    test_done;
  end
endmodule
